// [inc/isu_pkg.sv]
// Package for the integer shift unit: register map, encodings, field positions, helpers
// Operation
// - Both left shift forms are one operation, extension 4, moving bits upward.
// - Extension 7 selects the arithmetic right shift.
// - Extension 5 selects the logical right shift.
// - D0/D2/C0 byte operand, D1/D3/C1 wide; count one, count register, immediate.
// - Count is cut to its low five bits, giving zero to thirty-one.
// - Count comes from the immediate byte or the count register low byte.
// - Destination from register or memory; result written back to the same place.
// - Count-one encodings carry no count byte and never read the count register.
// - Bits pushed out pass through carry; carry ends holding the last one out.
// - Left shift moves the top bit into carry and clears the bottom bit.
// - Logical right shift moves the bottom bit into carry, clears the top.
// - Arithmetic right shift fills vacated top bits with the original sign.
// - Arithmetic right shift rounds toward negative infinity, unlike signed divide.
// - Overflow gets a defined value only when the effective count is one.
// - One-place left shift: overflow is result top bit XOR new carry.
// - One-place arithmetic right shift always clears overflow.
// - One-place logical right shift loads overflow with the original top bit.
// - A masked count of zero leaves every flag unchanged.
// - A nonzero shift sets sign, zero and parity from the result.
// - Overflow is unspecified when the count is not one.
// - Carry is unspecified for left and logical right counts at least operand width.
package isu_pkg;

    // Register byte offsets on the bus
    localparam logic [4:0]  ISU_ADDR_CTRL    = 5'h00;
    localparam logic [4:0]  ISU_ADDR_OPERAND = 5'h04;
    localparam logic [4:0]  ISU_ADDR_COUNT   = 5'h08;
    localparam logic [4:0]  ISU_ADDR_FLAGS   = 5'h0C;
    localparam logic [4:0]  ISU_ADDR_CMD     = 5'h10;

    // Control register fields
    localparam int          CTRL_OPC_LSB     = 0;
    localparam int          CTRL_EXT_LSB     = 8;
    localparam int          CTRL_SIZE32_BIT  = 11;
    localparam int          CTRL_MEM_BIT     = 12;

    // Count register fields: immediate byte and count register low byte
    localparam int          COUNT_IMM_LSB    = 0;
    localparam int          COUNT_REG_LSB    = 8;

    // Flag positions in the flags word
    localparam int          FLAG_CARRY       = 0;
    localparam int          FLAG_PARITY      = 2;
    localparam int          FLAG_AUX_CARRY   = 4;
    localparam int          FLAG_ZERO        = 6;
    localparam int          FLAG_SIGN        = 7;
    localparam int          FLAG_OVERFLOW    = 11;

    // Status fields
    localparam int          ST_DONE          = 0;
    localparam int          ST_BAD           = 1;
    localparam int          ST_CREG          = 2;
    localparam int          ST_MEM           = 3;
    localparam int          ST_CNT_LSB       = 8;

    // Reset values
    localparam logic [31:0] CTRL_RST         = 32'h0000_0000;
    localparam logic [31:0] OPERAND_RST      = 32'h0000_0000;
    localparam logic [15:0] COUNT_RST        = 16'h0000;
    localparam logic [31:0] FLAGS_RST        = 32'h0000_0002;
    localparam logic [31:0] STATUS_RST       = 32'h0000_0000;

    // Opcode bytes and register-field extensions
    localparam logic [7:0]  OPC_BYTE_ONE     = 8'hD0;
    localparam logic [7:0]  OPC_WIDE_ONE     = 8'hD1;
    localparam logic [7:0]  OPC_BYTE_CREG    = 8'hD2;
    localparam logic [7:0]  OPC_WIDE_CREG    = 8'hD3;
    localparam logic [7:0]  OPC_BYTE_IMM     = 8'hC0;
    localparam logic [7:0]  OPC_WIDE_IMM     = 8'hC1;
    localparam logic [2:0]  EXT_LEFT         = 3'h4;
    localparam logic [2:0]  EXT_RIGHT        = 3'h5;
    localparam logic [2:0]  EXT_ARITH        = 3'h7;

    // Effective count is five bits wide
    localparam int          CNT_BITS         = 5;
    localparam logic [4:0]  CNT_ONE          = 5'h01;

    typedef enum logic [1:0] {OP_NONE, OP_LEFT, OP_RIGHT, OP_ARITH} isu_op_e;
    typedef enum logic [1:0] {SZ_8, SZ_16, SZ_32} isu_size_e;

    // Lanes that belong to an operand of the given size
    function automatic logic [31:0] size_mask(input isu_size_e sz);
        size_mask = (sz == SZ_8) ? 32'h0000_00FF : (sz == SZ_16) ? 32'h0000_FFFF : 32'hFFFF_FFFF;
    endfunction : size_mask

    // Most significant bit of an operand of the given size
    function automatic logic size_msb(input logic [31:0] v, input isu_size_e sz);
        size_msb = (sz == SZ_8) ? v[7] : (sz == SZ_16) ? v[15] : v[31];
    endfunction : size_msb

endpackage : isu_pkg

// [logic/isu_shift_core.sv]
// Single-pass barrel shifter for 8, 16 and 32 bit operands
`timescale 1ns/1ps
module isu_shift_core #(
    parameter int W = 32
) (
    input  wire logic [W-1:0]        dest,
    input  wire isu_pkg::isu_size_e  size,
    input  wire isu_pkg::isu_op_e    op,
    input  wire logic [4:0]          cnt,
    output logic      [W-1:0]        res,
    output logic                     carry
);
    import isu_pkg::*;

    logic [W-1:0]   mask;
    logic           fill;
    logic [2*W:0]   right_ext;
    logic [2*W:0]   right_sh;
    logic [2*W-1:0] left_sh;
    logic [5:0]     width;

    // Fill is the original sign only for the arithmetic form
    assign mask      = size_mask(size);
    assign fill      = (op == OP_ARITH) & size_msb(dest, size);
    assign width     = (size == SZ_8) ? 6'h08 : (size == SZ_16) ? 6'h10 : 6'h20;

    // One guard bit below the operand catches the last bit out on a right shift
    assign right_ext = {{W{fill}}, (dest & mask) | (fill ? ~mask : '0), 1'b0};
    assign right_sh  = right_ext >> cnt;
    assign left_sh   = {{W{1'b0}}, dest & mask} << cnt;

    // Carry is the bit just beyond the boundary after the whole move
    always_comb
    begin
        if (op == OP_LEFT)
        begin
            res   = left_sh[W-1:0] & mask;
            carry = left_sh[width];
        end
        else
        begin
            res   = right_sh[W:1] & mask;
            carry = right_sh[0];
        end
    end

endmodule : isu_shift_core

// [logic/isu_shift_unit.sv]
// Integer shift unit with Avalon-MM register slave
//
// Implementation choices: the address map and the Avalon-MM register port.
`timescale 1ns/1ps
module isu_shift_unit (
    input  wire logic        ref_clk,
    input  wire logic        reset,
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest
);
    import isu_pkg::*;

    logic [31:0]  ctrl_q;
    logic [31:0]  operand_q;
    logic [15:0]  count_q;
    logic [31:0]  flags_q;
    logic [31:0]  flags_d;
    logic [31:0]  status_q;
    logic [31:0]  rdata_q;
    logic [31:0]  rdata_d;
    logic         wait_q;
    logic [31:0]  sh_res;
    logic         sh_carry;

    // Byte-lane merge for register writes
    function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  be);
        logic [31:0] m;
        m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
        be_merge = (old_v & ~m) | (new_v & m);
    endfunction : be_merge

    // Bus handshake: first cycle of a request is taken, second is answered
    wire          req        = avs_read | avs_write;
    wire          take       = req & wait_q;
    wire          commit_wr  = avs_write & ~wait_q;
    wire          sel_ctrl   = (avs_address == ISU_ADDR_CTRL);
    wire          sel_oper   = (avs_address == ISU_ADDR_OPERAND);
    wire          sel_count  = (avs_address == ISU_ADDR_COUNT);
    wire          sel_flags  = (avs_address == ISU_ADDR_FLAGS);
    wire          sel_cmd    = (avs_address == ISU_ADDR_CMD);
    wire [31:0]   wr_merged  = be_merge(32'h0000_0000, avs_writedata, avs_byteenable);

    // Opcode byte and extension field as loaded by the decoder
    wire [7:0]    opc        = ctrl_q[CTRL_OPC_LSB +: 8];
    wire [2:0]    ext        = ctrl_q[CTRL_EXT_LSB +: 3];
    wire          is_byte    = (opc == OPC_BYTE_ONE) | (opc == OPC_BYTE_CREG)
                             | (opc == OPC_BYTE_IMM);
    wire          is_wide    = (opc == OPC_WIDE_ONE) | (opc == OPC_WIDE_CREG)
                             | (opc == OPC_WIDE_IMM);
    wire          src_one    = (opc == OPC_BYTE_ONE) | (opc == OPC_WIDE_ONE);
    wire          src_reg    = (opc == OPC_BYTE_CREG) | (opc == OPC_WIDE_CREG);

    // Both left forms share extension 4; unused extensions decode to none
    wire isu_op_e op         = (ext == EXT_LEFT) ? OP_LEFT
                             : (ext == EXT_RIGHT) ? OP_RIGHT
                             : (ext == EXT_ARITH) ? OP_ARITH
                             : OP_NONE;
    wire          valid      = (is_byte | is_wide) & (op != OP_NONE);
    wire isu_size_e size     = is_byte ? SZ_8 : (ctrl_q[CTRL_SIZE32_BIT] ? SZ_32 : SZ_16);

    // Count-one forms never look at the count register or the immediate
    wire [7:0]    raw_cnt    = src_one ? 8'h01
                             : src_reg ? count_q[COUNT_REG_LSB +: 8]
                             : count_q[COUNT_IMM_LSB +: 8];
    wire [4:0]    cnt_eff    = raw_cnt[CNT_BITS-1:0];
    wire          cnt_zero   = (cnt_eff == 5'h00);
    wire          cnt_one    = (cnt_eff == CNT_ONE);

    // Command write starts the shift; an invalid encoding only flags itself
    wire          go         = commit_wr & sel_cmd;
    wire          run        = go & valid;
    wire [31:0]   keep_mask  = ~size_mask(size);
    wire [31:0]   wb_val     = (operand_q & keep_mask) | sh_res;
    wire          dest_msb   = size_msb(operand_q, size);
    wire          res_msb    = size_msb(sh_res, size);

    isu_shift_core #(
        .W      (32)
    ) u_core (
        .dest   (operand_q),
        .size   (size),
        .op     (op),
        .cnt    (cnt_eff),
        .res    (sh_res),
        .carry  (sh_carry)
    );

    // Flag update; overflow and aux carry are kept when undefined, cheapest choice
    always_comb
    begin
        flags_d = flags_q;
        if (!cnt_zero)
        begin
            flags_d[FLAG_CARRY]  = sh_carry;
            flags_d[FLAG_SIGN]   = res_msb;
            flags_d[FLAG_ZERO]   = (sh_res == 32'h0000_0000);
            flags_d[FLAG_PARITY] = ~^sh_res[7:0];
            if (cnt_one)
            begin
                case (op)
                    OP_LEFT:  flags_d[FLAG_OVERFLOW] = res_msb ^ sh_carry;
                    OP_ARITH: flags_d[FLAG_OVERFLOW] = 1'b0;
                    OP_RIGHT: flags_d[FLAG_OVERFLOW] = dest_msb;
                    default:  flags_d[FLAG_OVERFLOW] = flags_q[FLAG_OVERFLOW];
                endcase
            end
        end
    end

    // Read mux, sampled on the taking cycle so data stands in the answer cycle
    always_comb
    begin
        if (sel_ctrl)
            rdata_d = ctrl_q;
        else if (sel_oper)
            rdata_d = operand_q;
        else if (sel_count)
            rdata_d = {16'h0000, count_q};
        else if (sel_flags)
            rdata_d = flags_q;
        else if (sel_cmd)
            rdata_d = status_q;
        else
            rdata_d = 32'h0000_0000;
    end

    // One wait cycle per access; idle waitrequest stays high
    always_ff @(posedge ref_clk)
    begin
        if (reset)
            wait_q <= 1'b1;
        else
            wait_q <= ~take;
    end

    // Read data latched once per access
    always_ff @(posedge ref_clk)
    begin
        if (reset)
            rdata_q <= 32'h0000_0000;
        else if (take & avs_read)
            rdata_q <= rdata_d;
    end

    // Control register: opcode, extension, size and destination kind
    always_ff @(posedge ref_clk)
    begin
        if (reset)
            ctrl_q <= CTRL_RST;
        else if (commit_wr & sel_ctrl)
            ctrl_q <= be_merge(ctrl_q, avs_writedata, avs_byteenable);
    end

    // Operand is overwritten in place by the result
    always_ff @(posedge ref_clk)
    begin
        if (reset)
            operand_q <= OPERAND_RST;
        else if (run)
            operand_q <= wb_val;
        else if (commit_wr & sel_oper)
            operand_q <= be_merge(operand_q, avs_writedata, avs_byteenable);
    end

    // Count sources: immediate byte and count register low byte
    always_ff @(posedge ref_clk)
    begin
        if (reset)
            count_q <= COUNT_RST;
        else if (commit_wr & sel_count)
            count_q <= wr_merged[15:0] | (count_q & ~{{8{avs_byteenable[1]}},
                                                       {8{avs_byteenable[0]}}});
    end

    // Flags updated in place, like the operand
    always_ff @(posedge ref_clk)
    begin
        if (reset)
            flags_q <= FLAGS_RST;
        else if (run)
            flags_q <= flags_d;
        else if (commit_wr & sel_flags)
            flags_q <= be_merge(flags_q, avs_writedata, avs_byteenable);
    end

    // Status of the last command; a bad encoding changes neither operand nor flags
    always_ff @(posedge ref_clk)
    begin
        if (reset)
            status_q <= STATUS_RST;
        else if (go)
        begin
            status_q                       <= 32'h0000_0000;
            status_q[ST_DONE]              <= 1'b1;
            status_q[ST_BAD]               <= ~valid;
            status_q[ST_CREG]              <= src_reg;
            status_q[ST_MEM]               <= ctrl_q[CTRL_MEM_BIT];
            status_q[ST_CNT_LSB +: 5]      <= cnt_eff;
        end
    end

    // Outputs straight from flip-flops
    assign avs_waitrequest = wait_q;
    assign avs_readdata    = rdata_q;

    // Every taken access is answered on the next cycle and then released
    property p_bus_answer;
        @(posedge ref_clk) disable iff (reset)
        take |=> !avs_waitrequest ##1 avs_waitrequest;
    endproperty
    a_bus_answer: assert property (p_bus_answer)
        else $error("waitrequest did not drop for exactly one cycle");

    property p_one_count;
        @(posedge ref_clk) disable iff (reset)
        run && src_one |=> status_q[ST_CNT_LSB +: 5] == CNT_ONE && !status_q[ST_CREG];
    endproperty
    a_one_count: assert property (p_one_count)
        else $error("count-one opcode gave another count");

    property p_reg_count;
        @(posedge ref_clk) disable iff (reset)
        src_reg |-> cnt_eff == count_q[12:8];
    endproperty
    a_reg_count: assert property (p_reg_count)
        else $error("count register count not cut to five bits");

    property p_imm_count;
        @(posedge ref_clk) disable iff (reset)
        (is_byte | is_wide) && !src_one && !src_reg |-> cnt_eff == count_q[4:0];
    endproperty
    a_imm_count: assert property (p_imm_count)
        else $error("immediate count not taken");

    property p_zero_keep;
        @(posedge ref_clk) disable iff (reset)
        run && cnt_zero |=> flags_q == $past(flags_q) && operand_q == $past(operand_q);
    endproperty
    a_zero_keep: assert property (p_zero_keep)
        else $error("zero count changed flags or operand");

    property p_left_overflow;
        @(posedge ref_clk) disable iff (reset)
        run && cnt_one && op == OP_LEFT
        |=> flags_q[FLAG_OVERFLOW] == (flags_q[FLAG_CARRY] ^ $past(res_msb));
    endproperty
    a_left_overflow: assert property (p_left_overflow)
        else $error("left shift overflow wrong");

    property p_arith_overflow;
        @(posedge ref_clk) disable iff (reset)
        run && cnt_one && op == OP_ARITH |=> !flags_q[FLAG_OVERFLOW];
    endproperty
    a_arith_overflow: assert property (p_arith_overflow)
        else $error("arithmetic right overflow not cleared");

    property p_logic_overflow;
        @(posedge ref_clk) disable iff (reset)
        run && cnt_one && op == OP_RIGHT
        |=> flags_q[FLAG_OVERFLOW] == $past(dest_msb) && !$past(res_msb);
    endproperty
    a_logic_overflow: assert property (p_logic_overflow)
        else $error("logical right overflow or top bit wrong");

    property p_left_carry;
        @(posedge ref_clk) disable iff (reset)
        run && cnt_one && op == OP_LEFT
        |=> flags_q[FLAG_CARRY] == $past(dest_msb) && !operand_q[0];
    endproperty
    a_left_carry: assert property (p_left_carry)
        else $error("left shift carry or low bit wrong");

    property p_right_carry;
        @(posedge ref_clk) disable iff (reset)
        run && !cnt_zero && op != OP_LEFT && cnt_one
        |=> flags_q[FLAG_CARRY] == $past(operand_q[0]);
    endproperty
    a_right_carry: assert property (p_right_carry)
        else $error("right shift carry not the low bit");

    property p_arith_sign;
        @(posedge ref_clk) disable iff (reset)
        run && op == OP_ARITH |=> $past(res_msb) == $past(dest_msb);
    endproperty
    a_arith_sign: assert property (p_arith_sign)
        else $error("arithmetic right shift lost the sign");

    property p_result_flags;
        @(posedge ref_clk) disable iff (reset)
        run && !cnt_zero
        |=> flags_q[FLAG_ZERO] == ($past(sh_res) == 32'h0000_0000)
            && flags_q[FLAG_SIGN] == $past(res_msb);
    endproperty
    a_result_flags: assert property (p_result_flags)
        else $error("sign or zero flag not from result");

    property p_writeback;
        @(posedge ref_clk) disable iff (reset)
        run |=> operand_q == $past(wb_val) && status_q[ST_DONE] && !status_q[ST_BAD];
    endproperty
    a_writeback: assert property (p_writeback)
        else $error("result not written back in place");

    property p_bad_op;
        @(posedge ref_clk) disable iff (reset)
        go && !valid |=> status_q[ST_BAD] && operand_q == $past(operand_q);
    endproperty
    a_bad_op: assert property (p_bad_op)
        else $error("bad encoding altered operand");

endmodule : isu_shift_unit

// [tb/isu_host_model.sv]
// Bus master model standing in for the decoder and operand path
`timescale 1ns/1ps
module isu_host_model (
    input  wire logic        ref_clk,
    output logic      [4:0]  avs_address,
    output logic             avs_read,
    output logic             avs_write,
    output logic      [31:0] avs_writedata,
    output logic      [3:0]  avs_byteenable,
    input  wire logic [31:0] avs_readdata,
    input  wire logic        avs_waitrequest
);
    // Idle bus at time zero; all lanes enabled, partial writes not exercised
    initial
    begin
        avs_address    = 5'h00;
        avs_read       = 1'b0;
        avs_write      = 1'b0;
        avs_writedata  = 32'h0000_0000;
        avs_byteenable = 4'hF;
    end

    // Write held until waitrequest is sampled low; data inverted once released
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= 1'b1;
        do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
        avs_write     <= 1'b0;
        avs_writedata <= ~d;
    endtask : wr

    // Read data taken at the very edge that sees waitrequest low
    task automatic rd(input logic [4:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        avs_address <= a;
        avs_read    <= 1'b1;
        do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
        d = avs_readdata;
        avs_read    <= 1'b0;
    endtask : rd
endmodule : isu_host_model

// [tb/tb.sv]
// Self-checking bench for the integer shift unit
`timescale 1ns/1ps
module tb;
    import isu_pkg::*;
    logic        ref_clk;
    logic        reset;
    logic [4:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [3:0]  avs_byteenable;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    int          bad_count;
    int          checked;

    // 100 MHz core clock
    initial ref_clk = 1'b0;
    always #5 ref_clk = ~ref_clk;

    isu_shift_unit DUT (.ref_clk(ref_clk), .reset(reset), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest));
    isu_host_model HOST (.ref_clk(ref_clk), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest));

    // Masked compare; unknowns inside the mask never match
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g,
                       input logic [31:0] m);
        checked++;
        if ((g & m) !== (e & m))
        begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", n, e & m, g & m);
        end
    endtask : chk

    // Runs one command and judges operand, flags and status against a reference
    task automatic t_shift(input logic [7:0] opc, input logic [2:0] ext, input logic s32,
        input logic mem, input logic [31:0] val, input logic [15:0] cw, input logic [31:0] flg);
        logic [31:0] m, v, res, ef, fm, g;
        logic [63:0] sx;
        logic [64:0] r;
        logic        cf, msb, creg;
        int          w, c;
        creg = (opc == OPC_BYTE_CREG) || (opc == OPC_WIDE_CREG);
        w = (opc inside {OPC_BYTE_ONE, OPC_BYTE_CREG, OPC_BYTE_IMM}) ? 8 : (s32 ? 32 : 16);
        c = (opc inside {OPC_BYTE_ONE, OPC_WIDE_ONE}) ? 1 : int'(creg ? cw[12:8] : cw[4:0]);
        m = (w == 32) ? 32'hFFFF_FFFF : ((32'h1 << w) - 32'h1);
        v = val & m;
        msb = v[w-1];
        sx = {32'h0, v} | ((ext == EXT_ARITH && msb) ? ~{32'h0, m} : 64'h0);
        r = (ext == EXT_LEFT) ? ({1'b0, sx} << c) : ({sx, 1'b0} >> c);
        res = ((ext == EXT_LEFT) ? r[31:0] : r[32:1]) & m;
        cf = (ext == EXT_LEFT) ? r[w] : r[0];
        ef = flg;
        ef[FLAG_CARRY] = cf;
        ef[FLAG_SIGN] = res[w-1];
        ef[FLAG_ZERO] = (res == 32'h0);
        ef[FLAG_PARITY] = ~^res[7:0];
        ef[FLAG_OVERFLOW] = (ext == EXT_ARITH) ? 1'b0 : msb;
        if (ext == EXT_LEFT) ef[FLAG_OVERFLOW] = res[w-1] ^ cf;
        fm = ~(32'h1 << FLAG_AUX_CARRY);
        fm[FLAG_OVERFLOW] = (c == 1);
        if (ext != EXT_ARITH && c >= w) fm[FLAG_CARRY] = 1'b0;
        if (c == 0)
        begin
            ef = flg;
            res = v;
            fm = 32'hFFFF_FFFF;
        end
        HOST.wr(ISU_ADDR_CTRL, {19'h0, mem, s32, ext, opc});
        HOST.wr(ISU_ADDR_OPERAND, val);
        HOST.wr(ISU_ADDR_COUNT, {16'h0, cw});
        HOST.wr(ISU_ADDR_FLAGS, flg);
        HOST.wr(ISU_ADDR_CMD, 32'h0000_0000);
        HOST.rd(ISU_ADDR_OPERAND, g);
        chk("operand", (val & ~m) | res, g, 32'hFFFF_FFFF);
        HOST.rd(ISU_ADDR_FLAGS, g);
        chk("flags", ef, g, fm);
        HOST.rd(ISU_ADDR_CMD, g);
        chk("status", {19'h0, c[4:0], 4'h0, mem, creg, 2'b01}, g, 32'h0000_1F0F);
    endtask : t_shift

    // Reset values and an unmapped address
    task automatic test_reset();
        logic [31:0] d;
        logic [4:0]  a [6] = '{ISU_ADDR_CTRL, ISU_ADDR_OPERAND, ISU_ADDR_COUNT,
                               ISU_ADDR_FLAGS, ISU_ADDR_CMD, 5'h14};
        logic [31:0] e [6] = '{CTRL_RST, OPERAND_RST, {16'h0, COUNT_RST}, FLAGS_RST,
                               STATUS_RST, 32'h0};
        for (int i = 0; i < 6; i++)
        begin
            HOST.rd(a[i], d);
            chk("reset read", e[i], d, 32'hFFFF_FFFF);
        end
        $display("test reset done");
    endtask : test_reset

    task automatic test_left();
        t_shift(OPC_BYTE_ONE, EXT_LEFT, 0, 0, 32'hA5A5_1281, 16'h0700, 32'h802);
        t_shift(OPC_WIDE_CREG, EXT_LEFT, 0, 1, 32'h1234_4003, 16'h2F05, 32'h2);
        t_shift(OPC_WIDE_IMM, EXT_LEFT, 1, 0, 32'h0000_0003, 16'h003F, 32'h0);
        $display("test left done");
    endtask : test_left

    task automatic test_right_logic();
        t_shift(OPC_WIDE_ONE, EXT_RIGHT, 1, 0, 32'h8000_0001, 16'h0000, 32'h0);
        t_shift(OPC_BYTE_CREG, EXT_RIGHT, 0, 0, 32'h0000_00F4, 16'h0303, 32'h0);
        t_shift(OPC_BYTE_IMM, EXT_RIGHT, 0, 0, 32'hFFFF_FF18, 16'h0024, 32'h0);
        $display("test right logical done");
    endtask : test_right_logic

    task automatic test_right_arith();
        t_shift(OPC_BYTE_ONE, EXT_ARITH, 0, 0, 32'h0000_0080, 16'h0000, 32'h0);
        t_shift(OPC_WIDE_IMM, EXT_ARITH, 0, 0, 32'h0000_FFF7, 16'h0002, 32'h0);
        t_shift(OPC_WIDE_CREG, EXT_ARITH, 1, 0, 32'h8000_0000, 16'h1F00, 32'h0);
        t_shift(OPC_WIDE_ONE, EXT_ARITH, 1, 1, 32'h7FFF_FFFF, 16'h0000, 32'h0);
        $display("test right arithmetic done");
    endtask : test_right_arith

    task automatic test_zero_count();
        t_shift(OPC_WIDE_IMM, EXT_RIGHT, 1, 0, 32'hDEAD_BEEF, 16'h0020, 32'h8D5);
        t_shift(OPC_BYTE_CREG, EXT_LEFT, 0, 0, 32'h0000_0055, 16'h4000, 32'h891);
        $display("test zero count done");
    endtask : test_zero_count

    // Undefined extension must leave operand and flags alone
    task automatic test_bad_code();
        logic [31:0] g;
        HOST.wr(ISU_ADDR_CTRL, {21'h0, 3'h6, OPC_WIDE_ONE});
        HOST.wr(ISU_ADDR_OPERAND, 32'h0F0F_1234);
        HOST.wr(ISU_ADDR_FLAGS, 32'h0000_08C7);
        HOST.wr(ISU_ADDR_CMD, 32'h0000_0000);
        HOST.rd(ISU_ADDR_OPERAND, g);
        chk("bad operand", 32'h0F0F_1234, g, 32'hFFFF_FFFF);
        HOST.rd(ISU_ADDR_FLAGS, g);
        chk("bad flags", 32'h0000_08C7, g, 32'hFFFF_FFFF);
        HOST.rd(ISU_ADDR_CMD, g);
        chk("bad status", 32'h0000_0003, g, 32'h0000_0003);
        $display("test bad code done");
    endtask : test_bad_code

    // Single exit point for both normal end and watchdog
    task automatic conclude();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : conclude

    // Main sequence, reset held four cycles
    initial
    begin
        bad_count = 0;
        checked = 0;
        reset = 1'b1;
        repeat (4) @(posedge ref_clk);
        reset <= 1'b0;
        test_reset();
        test_left();
        test_right_logic();
        test_right_arith();
        test_zero_count();
        test_bad_code();
        conclude();
    end

    // Watchdog well beyond the few hundred cycles the tests need
    initial
    begin
        repeat (5000) @(posedge ref_clk);
        bad_count++;
        conclude();
    end
endmodule : tb
